// ---- pkg/rad_pkg.sv ----
// Constants, types and register layout of the region attribute decoder and fault checker.
// Assumes a single 125 MHz clock domain and a classic Wishbone register port.
// How it works
// - Memory type from type_ext_field plus C,B
// - 00000 strongly ordered shareable; 00001 shareable device
// - 010,0,0 is non-shareable device
// - Normal memory shareability follows the shareable flag
// - 001,0,0 is normal non-cacheable inner and outer
// - 001,1,1 is normal write-back write-allocate both levels
// - Top type bit set: outer from type, inner from C,B
// - Policy codes: 00 none, 01 WBWA, 10 and 11 reserved
// - Inner attributes drive the inner sideband
// - Outer attributes drive the AxCACHE sideband
// - Control bit 0 switches protection on or off
// - TCM slave port accesses skip all checks
// - Faults abort: prefetch for fetch, data otherwise
// - Faulting access issues no master bus transaction
// - Enabled, address outside enabled subregions: background fault
// - Privileged access with background region: no background fault
// - Permission violation of matching region faults
// - Misaligned strict data access raises alignment fault
// - Strict-alignment control bit aligns all data accesses
// - Highest numbered matching region wins
// - Default-map bit: privileged uses default map, user faults
// - TCM addresses are normal non-shareable, permissions kept
`default_nettype none
package rad_pkg;
    // Register byte offsets
    localparam logic [11:0] RAD_CTRL_OFS     = 12'h000;
    localparam logic [11:0] RAD_FINFO_OFS    = 12'h004;
    localparam logic [11:0] RAD_FADDR_OFS    = 12'h008;
    localparam logic [11:0] RAD_REGION_OFS   = 12'h040;
    localparam logic [11:0] RAD_REGION_STEP  = 12'h010;
    localparam logic [3:0]  RAD_RBASE_OFS    = 4'h0;
    localparam logic [3:0]  RAD_RSIZE_OFS    = 4'h4;
    localparam logic [3:0]  RAD_RACC_OFS     = 4'h8;
    // Control word fields
    localparam int          RAD_CTRL_EN_BIT  = 0;
    localparam int          RAD_CTRL_ALN_BIT = 1;
    localparam int          RAD_CTRL_DM_BIT  = 17;
    localparam logic [31:0] RAD_CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] RAD_CTRL_MASK    = 32'h0002_0003;
    // Region size word: enable bit 0, size 5:1, subregion disable 15:8
    localparam logic [31:0] RAD_RSIZE_MASK   = 32'h0000_FF3F;
    localparam logic [4:0]  RAD_SIZE_MIN     = 5'h07;
    // Region access word: B 0, C 1, S 2, type ext 5:3, AP 10:8, XN 12
    localparam logic [31:0] RAD_RACC_MASK    = 32'h0000_173F;
    localparam logic [31:0] RAD_RBASE_MASK   = 32'hFFFF_FF00;
    // Fault info: kind 1:0, fetch 2, write 3, sticky seen 8
    localparam int          RAD_FSEEN_BIT    = 8;
    // Memory types
    typedef enum logic [1:0] {RAD_MT_SO = 2'h0, RAD_MT_DEV = 2'h1, RAD_MT_NORM = 2'h2} rad_mtype_t;
    // Policy codes
    localparam logic [1:0]  RAD_POL_NC       = 2'h0;
    localparam logic [1:0]  RAD_POL_WBWA     = 2'h1;
    // Fault kinds
    typedef enum logic [1:0] {RAD_F_NONE = 2'h0, RAD_F_BG = 2'h1, RAD_F_PERM = 2'h2, RAD_F_ALIGN = 2'h3} rad_fkind_t;
    // Access request from the pipeline
    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic        fetch;
        logic        priv;
        logic [1:0]  size;      // log2 of bytes
        logic        strict;    // instruction demands alignment
        logic        tcm;       // address served by tightly coupled memory
        logic        tcm_slave; // arrives through the TCM slave port
    } rad_req_t;
    // Decoded attributes
    typedef struct packed {
        rad_mtype_t  mtype;
        logic        shareable;
        logic [1:0]  inner;
        logic [1:0]  outer;
    } rad_attr_t;
endpackage
`default_nettype wire

// ---- src/rad_mpu.sv ----
// Region attribute decoder and protection fault checker with a Wishbone register slave.
// Assumes the pipeline presents one access per cycle and all inputs are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module rad_mpu #(
    parameter int NREG = 12    // Number of regions
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [11:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Access request
    input  wire logic              req_valid_i,
    input  wire rad_pkg::rad_req_t req_i,
    // Access answer
    output logic                   resp_valid_o,
    output logic                   fault_o,
    output rad_pkg::rad_fkind_t    fault_kind_o,
    output logic                   prefetch_abort_o,
    output logic                   data_abort_o,
    output rad_pkg::rad_attr_t     attr_o,
    // Master bus issue
    output logic                   axi_req_valid_o,
    output logic      [31:0]       axi_addr_o,
    output logic                   axi_write_o,
    output logic      [3:0]        inner_attr_sideband_o,
    output logic      [3:0]        outer_attr_sideband_o
);
    import rad_pkg::*;

    // Elaboration check: the region index is four bits wide, so at most 16 regions fit
    if (NREG < 1 || NREG > 16) begin : g_nreg_bad
        $error("NREG must lie between 1 and 16");
    end

    // Region storage
    logic [31:0] rbase_q [NREG];   // Region base addresses
    logic [31:0] rsize_q [NREG];   // Enable, size and subregion disables
    logic [31:0] racc_q  [NREG];   // Type, policy and permission fields
    logic [31:0] ctrl_q;           // System control word
    logic [31:0] finfo_q;          // Last fault description
    logic [31:0] faddr_q;          // Last fault address
    logic        ack_q;            // Wishbone acknowledge
    logic [31:0] rdat_q;           // Wishbone read data
    rad_req_t    req_q;            // Request held for the answer

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // Address match with subregion check
    function automatic logic region_hit(input logic [31:0] base, input logic [31:0] szw,
                                        input logic [31:0] addr);
        logic [4:0]  sz;
        logic [31:0] mask;
        logic [31:0] sh;
        logic [2:0]  idx;
        sz   = (szw[5:1] < RAD_SIZE_MIN) ? RAD_SIZE_MIN : szw[5:1];
        mask = 32'hFFFFFFFF << ({1'b0, sz} + 6'h01);
        sh   = addr >> ({1'b0, sz} - 6'h02);
        idx  = sh[2:0];
        return szw[0] && (((addr ^ base) & mask) == 32'h0) && !szw[8 + idx];
    endfunction

    // Permission check from the 3-bit access field and execute-never
    function automatic logic perm_ok(input logic [2:0] ap, input logic xn, input rad_req_t r);
        logic rd;
        logic wr;
        case (ap)
            3'h1:    begin rd = r.priv; wr = r.priv; end
            3'h2:    begin rd = 1'b1;   wr = r.priv; end
            3'h3:    begin rd = 1'b1;   wr = 1'b1;   end
            3'h5:    begin rd = r.priv; wr = 1'b0;   end
            3'h6:    begin rd = 1'b1;   wr = 1'b0;   end
            default: begin rd = 1'b0;   wr = 1'b0;   end   // No access or reserved
        endcase
        // Fetch needs read rights too, since literals sit inline with code
        if (r.fetch) begin
            return rd && !xn;
        end
        return r.write ? wr : rd;
    endfunction

    // Type and policy decode of {type_ext_field, C, B, S}
    function automatic rad_attr_t decode_attr(input logic [2:0] type_ext_field, input logic c,
                                              input logic b, input logic s);
        rad_attr_t a;
        a = '{mtype: RAD_MT_SO, shareable: 1'b1, inner: RAD_POL_NC, outer: RAD_POL_NC};
        if (type_ext_field[2]) begin
            // Any reserved policy code falls back to strongly ordered
            if (!type_ext_field[1] && !c) begin
                a = '{mtype: RAD_MT_NORM, shareable: s, inner: {c, b}, outer: type_ext_field[1:0]};
            end
        end else begin
            case ({type_ext_field, c, b})
                5'h00:   a = '{mtype: RAD_MT_SO, shareable: 1'b1, inner: RAD_POL_NC, outer: RAD_POL_NC};
                5'h01:   a = '{mtype: RAD_MT_DEV, shareable: 1'b1, inner: RAD_POL_NC, outer: RAD_POL_NC};
                5'h04:   a = '{mtype: RAD_MT_NORM, shareable: s, inner: RAD_POL_NC, outer: RAD_POL_NC};
                5'h07:   a = '{mtype: RAD_MT_NORM, shareable: s, inner: RAD_POL_WBWA, outer: RAD_POL_WBWA};
                5'h08:   a = '{mtype: RAD_MT_DEV, shareable: 1'b0, inner: RAD_POL_NC, outer: RAD_POL_NC};
                default: a = '{mtype: RAD_MT_SO, shareable: 1'b1, inner: RAD_POL_NC, outer: RAD_POL_NC};
            endcase
        end
        return a;
    endfunction

    // Bus cache code from type and one policy level; inner and outer share it
    function automatic logic [3:0] cache_code(input rad_mtype_t mt, input logic [1:0] pol);
        if (mt == RAD_MT_SO) begin
            return 4'h0;
        end else if (mt == RAD_MT_DEV) begin
            return 4'h1;
        end
        return (pol == RAD_POL_WBWA) ? 4'hF : 4'h3;
    endfunction

    // Wishbone decode
    logic        wb_go;            // Request pending and not yet answered
    logic        wb_wr;            // Write takes effect this cycle
    logic [11:0] roff;             // Offset into region window
    logic [3:0]  ridx;             // Region index
    logic        rsel;             // Offset falls in a populated region slot
    assign wb_go = wb_cyc_i && wb_stb_i && !ack_q;
    assign wb_wr = wb_go && wb_we_i;
    assign roff  = wb_adr_i - RAD_REGION_OFS;
    assign ridx  = roff[7:4];
    assign rsel  = (wb_adr_i >= RAD_REGION_OFS) && (roff[11:8] == 4'h0) && (32'(ridx) < NREG);

    // Answer one cycle after the request; released for one cycle afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_go;
        end
    end

    // Read mux; unmapped offsets read zero and are still acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0;
        end else if (wb_go && !wb_we_i) begin
            rdat_q <= 32'h0;
            if (wb_adr_i == RAD_CTRL_OFS) begin
                rdat_q <= ctrl_q;
            end else if (wb_adr_i == RAD_FINFO_OFS) begin
                rdat_q <= finfo_q;
            end else if (wb_adr_i == RAD_FADDR_OFS) begin
                rdat_q <= faddr_q;
            end else if (rsel) begin
                case (roff[3:0])
                    RAD_RBASE_OFS: rdat_q <= rbase_q[ridx];
                    RAD_RSIZE_OFS: rdat_q <= rsize_q[ridx];
                    RAD_RACC_OFS:  rdat_q <= racc_q[ridx];
                    default:       rdat_q <= 32'h0;
                endcase
            end
        end
    end
    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

    // Control word; software follows a change with barriers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= RAD_CTRL_RST;
        end else if (wb_wr && wb_adr_i == RAD_CTRL_OFS) begin
            ctrl_q <= merge_sel(ctrl_q, wb_dat_i, wb_sel_i, RAD_CTRL_MASK);
        end
    end

    // Region registers; all regions start disabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NREG; i++) begin
                rbase_q[i] <= 32'h0;
                rsize_q[i] <= 32'h0;
                racc_q[i]  <= 32'h0;
            end
        end else if (wb_wr && rsel) begin
            case (roff[3:0])
                RAD_RBASE_OFS: rbase_q[ridx] <= merge_sel(rbase_q[ridx], wb_dat_i, wb_sel_i, RAD_RBASE_MASK);
                RAD_RSIZE_OFS: rsize_q[ridx] <= merge_sel(rsize_q[ridx], wb_dat_i, wb_sel_i, RAD_RSIZE_MASK);
                RAD_RACC_OFS:  racc_q[ridx]  <= merge_sel(racc_q[ridx], wb_dat_i, wb_sel_i, RAD_RACC_MASK);
                default: ;
            endcase
        end
    end

    // Region lookup: later regions override earlier ones
    logic        hit_any;          // Some enabled subregion matches
    logic [31:0] hit_acc;          // Access word of the winning region
    always_comb begin
        hit_any = 1'b0;
        hit_acc = 32'h0;
        for (int i = 0; i < NREG; i++) begin
            if (region_hit(rbase_q[i], rsize_q[i], req_i.addr)) begin
                hit_any = 1'b1;
                hit_acc = racc_q[i];
            end
        end
    end

    // Fault evaluation
    logic        mpu_en;           // Protection switched on
    logic        misalign;         // Address not a multiple of size
    logic        need_align;       // Data access requiring alignment
    logic        use_default;      // Privileged miss served by default map
    rad_fkind_t  fkind;            // Fault to report
    rad_attr_t   attr_d;           // Attributes for the access
    logic [3:0]  amask;            // Low address bits that must be zero
    assign mpu_en      = ctrl_q[RAD_CTRL_EN_BIT];
    assign amask       = 4'((5'h01 << req_i.size) - 5'h01);
    assign misalign    = (req_i.addr[3:0] & amask) != 4'h0;
    assign need_align  = !req_i.fetch && (req_i.strict || ctrl_q[RAD_CTRL_ALN_BIT]);
    assign use_default = !hit_any && req_i.priv && ctrl_q[RAD_CTRL_DM_BIT];

    always_comb begin
        fkind = RAD_F_NONE;
        if (req_i.tcm_slave) begin
            fkind = RAD_F_NONE;
        end else if (need_align && misalign) begin
            fkind = RAD_F_ALIGN;
        end else if (mpu_en && !hit_any && !use_default) begin
            fkind = RAD_F_BG;
        end else if (mpu_en && hit_any && !perm_ok(hit_acc[10:8], hit_acc[12], req_i)) begin
            fkind = RAD_F_PERM;
        end
    end

    // Attribute choice: default map when off or on a privileged miss
    always_comb begin
        attr_d = '{mtype: RAD_MT_NORM, shareable: 1'b0, inner: RAD_POL_NC, outer: RAD_POL_NC};
        if (mpu_en && hit_any) begin
            attr_d = decode_attr(hit_acc[5:3], hit_acc[1], hit_acc[0], hit_acc[2]);
        end
        if (req_i.tcm) begin
            attr_d = '{mtype: RAD_MT_NORM, shareable: 1'b0, inner: RAD_POL_NC, outer: RAD_POL_NC};
        end
    end

    // Answer registers; one access answered per cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_valid_o     <= 1'b0;
            fault_o          <= 1'b0;
            fault_kind_o     <= RAD_F_NONE;
            prefetch_abort_o <= 1'b0;
            data_abort_o     <= 1'b0;
            attr_o           <= '0;
            req_q            <= '0;
        end else begin
            resp_valid_o     <= req_valid_i;
            fault_o          <= req_valid_i && (fkind != RAD_F_NONE);
            fault_kind_o     <= req_valid_i ? fkind : RAD_F_NONE;
            prefetch_abort_o <= req_valid_i && (fkind != RAD_F_NONE) && req_i.fetch;
            data_abort_o     <= req_valid_i && (fkind != RAD_F_NONE) && !req_i.fetch;
            if (req_valid_i) begin
                attr_o <= attr_d;
                req_q  <= req_i;
            end
        end
    end

    // Master bus issue; TCM hits and faults never reach the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            axi_req_valid_o       <= 1'b0;
            axi_addr_o            <= 32'h0;
            axi_write_o           <= 1'b0;
            inner_attr_sideband_o <= 4'h0;
            outer_attr_sideband_o <= 4'h0;
        end else begin
            axi_req_valid_o <= req_valid_i && (fkind == RAD_F_NONE) && !req_i.tcm && !req_i.tcm_slave;
            if (req_valid_i) begin
                axi_addr_o            <= req_i.addr;
                axi_write_o           <= req_i.write;
                inner_attr_sideband_o <= cache_code(attr_d.mtype, attr_d.inner);
                outer_attr_sideband_o <= cache_code(attr_d.mtype, attr_d.outer);
            end
        end
    end

    // Fault record; a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            finfo_q <= 32'h0;
            faddr_q <= 32'h0;
        end else begin
            if (wb_wr && wb_adr_i == RAD_FINFO_OFS && wb_sel_i[1] && wb_dat_i[RAD_FSEEN_BIT]) begin
                finfo_q[RAD_FSEEN_BIT] <= 1'b0;
            end
            if (req_valid_i && fkind != RAD_F_NONE) begin
                finfo_q[3:0]           <= {req_i.write, req_i.fetch, fkind};
                finfo_q[RAD_FSEEN_BIT] <= 1'b1;
                faddr_q                <= req_i.addr;
            end
        end
    end

    // Checks
    logic wr_ctrl;                 // Control write this cycle
    assign wr_ctrl = wb_wr && wb_adr_i == RAD_CTRL_OFS && wb_sel_i[0];

    // Faults stay off the bus and abort the matching stream
    fault_no_bus_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_o |-> !axi_req_valid_o) else $error("Faulting access reached the bus");
    abort_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_o |-> (prefetch_abort_o == req_q.fetch) && (data_abort_o == !req_q.fetch))
        else $error("Abort kind does not match access kind");
    // Decoded attributes
    so_shareable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_valid_o && attr_o.mtype == RAD_MT_SO |-> attr_o.shareable)
        else $error("Strongly ordered memory not shareable");
    // Fault classes and the paths that skip them
    slave_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.tcm_slave |=> !fault_o && !axi_req_valid_o)
        else $error("TCM slave access was checked");
    align_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !req_i.tcm_slave && !req_i.fetch && misalign && ctrl_q[RAD_CTRL_ALN_BIT]
        |=> fault_o && fault_kind_o == RAD_F_ALIGN) else $error("Missed alignment fault");
    user_bg_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && mpu_en && !hit_any && !req_i.priv && !req_i.tcm_slave && !(need_align && misalign)
        |=> fault_kind_o == RAD_F_BG) else $error("User miss did not fault");
    priv_dm_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && mpu_en && !hit_any && req_i.priv && ctrl_q[RAD_CTRL_DM_BIT]
        |=> fault_kind_o != RAD_F_BG) else $error("Privileged miss faulted with default map");
    off_no_check_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !mpu_en |=> fault_kind_o != RAD_F_BG && fault_kind_o != RAD_F_PERM)
        else $error("Region fault while protection off");
    // Control word, TCM attributes and sideband codes
    enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl ##1 !wr_ctrl |-> ctrl_q[RAD_CTRL_EN_BIT] == $past(wb_dat_i[0]))
        else $error("Enable bit not written");
    tcm_attr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_valid_o && req_q.tcm |-> attr_o.mtype == RAD_MT_NORM && !attr_o.shareable && !axi_req_valid_o)
        else $error("TCM attributes wrong");
    outer_wb_a: assert property (@(posedge clk_i) disable iff (rst_i)
        axi_req_valid_o && attr_o.mtype == RAD_MT_NORM && attr_o.outer == RAD_POL_WBWA
        |-> outer_attr_sideband_o == 4'hF) else $error("Outer sideband not write-back");
    inner_nc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        axi_req_valid_o && attr_o.mtype == RAD_MT_NORM && attr_o.inner == RAD_POL_NC
        |-> inner_attr_sideband_o == 4'h3) else $error("Inner sideband not non-cacheable");
    // Register bus handshake
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("Acknowledge held two cycles");

    perm_fault_c: cover property (@(posedge clk_i) disable iff (rst_i) fault_o && fault_kind_o == RAD_F_PERM);
    bg_fault_c:   cover property (@(posedge clk_i) disable iff (rst_i) fault_o && fault_kind_o == RAD_F_BG);
    wb_issue_c:   cover property (@(posedge clk_i) disable iff (rst_i) axi_req_valid_o && outer_attr_sideband_o == 4'hF);
    fetch_abt_c:  cover property (@(posedge clk_i) disable iff (rst_i) prefetch_abort_o);
endmodule // rad_mpu
`default_nettype wire

// ---- verification/rad_axi_sink.sv ----
// Behavioural stand-in for the master bus beyond the block: counts issues.
// Assumes issue pulses are one cycle wide and synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module rad_axi_sink (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Issue pulse and running count
    input  wire logic        valid_i,
    output logic      [15:0] cnt_o
);
    // Takes every issue at once; the block has no back-pressure to stall
    always_ff @(posedge clk_i) begin
        if (rst_i) cnt_o <= 16'h0000;
        else if (valid_i) cnt_o <= cnt_o + 16'h0001;
    end
endmodule // rad_axi_sink
`default_nettype wire

// ---- verification/test_rad_mpu.sv ----
// Self-checking bench for the region attribute decoder and fault checker.
// Assumes each access is answered exactly one cycle after it is taken.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_rad_mpu;
    import rad_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, rv = 0, ack, rsp, flt, pab, dab, iss, s, awr;
    logic [11:0] adr = 12'h000;
    logic [31:0] dat = 32'h0000_0000, rd, rdat, aadr;
    logic [3:0]  isb, osb;
    logic [10:0] xa;
    logic [15:0] cnt, c0;
    rad_req_t    rq = '0;
    rad_fkind_t  fk;
    rad_attr_t   at;
    integer      seed = 86165, err_total = 0, n_tests = 0, i;
    always #4 clk_i = ~clk_i;
    rad_mpu i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .req_valid_i(rv), .req_i(rq),
        .resp_valid_o(rsp), .fault_o(flt), .fault_kind_o(fk), .prefetch_abort_o(pab), .data_abort_o(dab),
        .attr_o(at), .axi_req_valid_o(iss), .axi_addr_o(aadr), .axi_write_o(awr), .inner_attr_sideband_o(isb),
        .outer_attr_sideband_o(osb));
    rad_axi_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .valid_i(iss), .cnt_o(cnt));
    // Expected type, shareable, inner and outer sideband codes; anything odd falls back to strongly ordered
    function automatic logic [10:0] ex(input logic [4:0] e, input logic sh);
        if (e == 5'b00001) return {RAD_MT_DEV, 1'b1, 8'h11};
        if (e == 5'b01000) return {RAD_MT_DEV, 1'b0, 8'h11};
        if (e == 5'b00100) return {RAD_MT_NORM, sh, 8'h33};
        if (e == 5'b00111) return {RAD_MT_NORM, sh, 8'hFF};
        if (e[4] && !e[3] && !e[1]) return {RAD_MT_NORM, sh, e[0] ? 4'hF : 4'h3, e[2] ? 4'hF : 4'h3};
        return {RAD_MT_SO, 1'b1, 8'h00};
    endfunction
    // Classic single cycle; the request stands until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i) {cyc, we, adr, dat} <= {1'b1, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
    endtask
    // One access, then its answer and whether the bus saw an issue
    task automatic acc(input rad_req_t r, input rad_fkind_t k);
        c0 = cnt;
        @(posedge clk_i) {rv, rq} <= {1'b1, r};
        @(posedge clk_i) rv <= 1'b0;
        @(posedge clk_i);
        `CHK("resp", 1'b1, rsp)
        `CHK("kind", k, fk)
        `CHK("pabort", (k != RAD_F_NONE) & r.fetch, pab)
        `CHK("dabort", (k != RAD_F_NONE) & ~r.fetch, dab)
        `CHK("addr", {r.addr, r.write}, {aadr, awr})
        @(posedge clk_i);
        `CHK("issue", (k == RAD_F_NONE && !r.tcm_slave && !r.tcm), cnt - c0)
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #40000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Region 0 covers all 4 GB; its size is set before enabling
        wb(1, 12'h044, 32'h0000_003F);
        wb(1, 12'h000, 32'h0000_0001);
        for (i = 0; i < 32; i++) begin
            s = 1'($random(seed));
            wb(1, 12'h048, {21'h0, 3'h3, 2'h0, i[4:2], s, i[1:0]});
            acc({$random(seed), 8'b00100000}, RAD_F_NONE);
            xa = ex(i[4:0], s);
            `CHK("type", xa[10:8], {at.mtype, at.shareable})
            `CHK("cache", xa[7:0], {isb, osb})
        end
        wb(1, 12'h048, 32'h0000_0108);
        acc({32'h0000_0010, 8'b10000000}, RAD_F_PERM);
        // Region 1 over the first 256 bytes, full access but execute-never, overrides region 0
        wb(1, 12'h054, 32'h0000_000F);
        wb(1, 12'h058, 32'h0000_1300);
        acc({32'h0000_0010, 8'b10000000}, RAD_F_NONE);
        acc({32'h0000_0010, 8'b01100000}, RAD_F_PERM);
        acc({32'h0000_0200, 8'b10000000}, RAD_F_PERM);
        acc({32'h0000_0011, 8'b00110100}, RAD_F_ALIGN);
        wb(1, 12'h000, 32'h0000_0003);
        acc({32'h0000_0011, 8'b00101000}, RAD_F_ALIGN);
        wb(1, 12'h044, 32'h0000_003E);
        wb(1, 12'h000, 32'h0000_0001);
        acc({32'h0000_0100, 8'b00100000}, RAD_F_BG);
        acc({32'h0000_0100, 8'b01100000}, RAD_F_BG);
        acc({32'h0000_0100, 8'b00100001}, RAD_F_NONE);
        wb(1, 12'h000, 32'h0002_0001);
        acc({32'h0000_0100, 8'b00100000}, RAD_F_NONE);
        acc({32'h0000_0100, 8'b00000000}, RAD_F_BG);
        wb(0, 12'h004, 32'h0000_0000);
        `CHK("finfo", 32'h0000_0101, rd)
        acc({32'h0000_0020, 8'b00000010}, RAD_F_NONE);
        `CHK("tcm", {RAD_MT_NORM, 1'b0}, {at.mtype, at.shareable})
        wb(0, 12'hFFC, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rd)
        wb(0, 12'h000, 32'h0000_0000);
        `CHK("ctrl", 32'h0002_0001, rd)
        end_of_test;
    end
endmodule // test_rad_mpu
`default_nettype wire
